//--- core/lupp_defs.svh
// register offsets, field positions, reset values and mode codes
// of the pixel unpack and palette stage; included by bare name
`ifndef LUPP_DEFS_SVH
`define LUPP_DEFS_SVH

// ----------------------------------------------------------------
// word addresses on the register bus
// ----------------------------------------------------------------
`define LUPP_CTRL_ADDR      8'h00
`define LUPP_STATUS_ADDR    8'h01
`define LUPP_PAL_SEL_BIT    7

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define LUPP_CTRL_MODE_LSB  0
`define LUPP_CTRL_MODE_MSB  2
`define LUPP_CTRL_DUAL      3
`define LUPP_CTRL_SWAP      4
`define LUPP_CTRL_BIGEND    5
`define LUPP_CTRL_PASSIVE   6
`define LUPP_CTRL_ENABLE    7
`define LUPP_CTRL_WIDTH     8
`define LUPP_CTRL_RESET     8'h00

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define LUPP_STAT_UP_FULL   0
`define LUPP_STAT_LO_FULL   1
`define LUPP_STAT_LEVEL_LSB 8

// ----------------------------------------------------------------
// operating mode codes
// ----------------------------------------------------------------
`define LUPP_MODE_1BPP      3'h0
`define LUPP_MODE_2BPP      3'h1
`define LUPP_MODE_4BPP      3'h2
`define LUPP_MODE_8BPP      3'h3
`define LUPP_MODE_16_555    3'h4
`define LUPP_MODE_16_565    3'h5
`define LUPP_MODE_12_444    3'h6

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define LUPP_FIFO_DEPTH     32
`define LUPP_PAL_WORDS      128

`endif

//--- core/lupp_pkg.sv
// types shared by the pixel unpack and palette stage
// assumes nothing of its surroundings
package lupp_pkg;

   // ----------------------------------------------------------------
   // one pixel on its way to the panel side
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        lower;
      logic [15:0] colour;
   } lupp_pix_s;

   // ----------------------------------------------------------------
   // register bus phases
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_LOOK,
      BUS_DONE
   } lupp_bus_e;

endpackage

//--- core/lupp_fifo.sv
// synchronous fifo with a registered output stage
// assumes one clock; depth a power of two
`timescale 1ns/1ps
`default_nettype none

module lupp_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 32
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       ce_i,
   input  wire logic [WIDTH-1:0]           in_data_i,
   input  wire logic                       in_valid_i,
   output logic                            in_ready_o,
   output logic [WIDTH-1:0]                out_data_o,
   output logic                            out_valid_o,
   input  wire logic                       out_ready_i,
   output logic [$clog2(DEPTH):0]          level_o
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   // handshake terms
   assign in_ready_o = (count_reg != FULL_CNT);
   assign push       = in_valid_i & in_ready_o;
   assign pop        = (count_reg != '0) & (~out_valid_o | out_ready_i);
   assign level_o    = count_reg;

   // storage write
   always_ff @(posedge clk_i) begin
      if (ce_i && push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else if (ce_i) begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (push && !pop) count_reg <= count_reg + 1'b1;
         else if (pop && !push) count_reg <= count_reg - 1'b1;
      end
   end

   // output stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
      end else if (ce_i) begin
         if (pop) begin
            out_data_o  <= mem[rd_ptr_reg];
            out_valid_o <= 1'b1;
         end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

//--- core/lupp_palette.sv
// dual-port palette store, two entries per word
// assumes one clock; port a read/write, port b read only
`timescale 1ns/1ps
`default_nettype none

module lupp_palette #(
   parameter int WORDS = 128
) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     ce_i,
   input  wire logic                     a_en_i,
   input  wire logic                     a_we_i,
   input  wire logic [3:0]               a_be_i,
   input  wire logic [$clog2(WORDS)-1:0] a_addr_i,
   input  wire logic [31:0]              a_wdata_i,
   output logic [31:0]                   a_rdata_o,
   input  wire logic                     b_en_i,
   input  wire logic [$clog2(WORDS)-1:0] b_addr_i,
   output logic [31:0]                   b_rdata_o
);

   logic [31:0] mem [WORDS];

   // port a byte-lane writes
   always_ff @(posedge clk_i) begin
      if (ce_i && a_we_i) begin
         for (int i = 0; i < 4; i++) begin
            if (a_be_i[i]) mem[a_addr_i][i*8 +: 8] <= a_wdata_i[i*8 +: 8];
         end
      end
   end

   // port a read for software check
   always_ff @(posedge clk_i) begin
      if (rst_i) a_rdata_o <= '0;
      else if (ce_i && a_en_i) a_rdata_o <= mem[a_addr_i];
   end

   // port b lookup, holds while not enabled
   always_ff @(posedge clk_i) begin
      if (rst_i) b_rdata_o <= '0;
      else if (ce_i && b_en_i) b_rdata_o <= mem[b_addr_i];
   end

endmodule

`default_nettype wire

//--- core/lupp_top.sv
// pixel unpack and palette lookup stage with its register slave
// assumes dma fifo words, panel side and bus master on MCLK_I
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lupp_defs.svh"

module lupp_top #(
   parameter int FIFO_DEPTH = `LUPP_FIFO_DEPTH,
   parameter int PAL_WORDS  = `LUPP_PAL_WORDS
) (
   input  wire logic        MCLK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic        CE_I,
   input  wire logic [31:0] UP_WORD_I,
   input  wire logic        UP_VALID_I,
   output logic             UP_READY_O,
   input  wire logic [31:0] LO_WORD_I,
   input  wire logic        LO_VALID_I,
   output logic             LO_READY_O,
   output logic [15:0]      PIX_COLOUR_O,
   output logic             PIX_LOWER_O,
   output logic             PIX_VALID_O,
   input  wire logic        PIX_READY_I,
   input  wire logic [7:0]  AV_ADDRESS_I,
   input  wire logic        AV_READ_I,
   input  wire logic        AV_WRITE_I,
   input  wire logic [31:0] AV_WRITEDATA_I,
   input  wire logic [3:0]  AV_BYTEENABLE_I,
   output logic [31:0]      AV_READDATA_O,
   output logic             AV_WAITREQUEST_O
);

   localparam int PAW = $clog2(PAL_WORDS);
   localparam int LW  = $clog2(FIFO_DEPTH) + 1;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------

   // index of the last pixel slot in a word
   function automatic logic [4:0] last_slot(input logic [2:0] mode);
      unique case (mode)
         `LUPP_MODE_1BPP: last_slot = 5'h1f;
         `LUPP_MODE_2BPP: last_slot = 5'h0f;
         `LUPP_MODE_4BPP: last_slot = 5'h07;
         `LUPP_MODE_8BPP: last_slot = 5'h03;
         default:         last_slot = 5'h01;
      endcase
   endfunction

   // cut the pixel of one slot from a word
   function automatic logic [15:0] extract(input logic [31:0] w,
                                           input logic [4:0]  slot,
                                           input logic [2:0]  mode);
      logic [31:0] sh;
      sh = 32'h0;
      unique case (mode)
         `LUPP_MODE_1BPP: sh = w >> slot;
         `LUPP_MODE_2BPP: sh = w >> {slot[3:0], 1'b0};
         `LUPP_MODE_4BPP: sh = w >> {slot[2:0], 2'b00};
         `LUPP_MODE_8BPP: sh = w >> {slot[1:0], 3'b000};
         default:         sh = w >> {slot[0], 4'h0};
      endcase
      unique case (mode)
         `LUPP_MODE_1BPP: extract = {15'h0000, sh[0]};
         `LUPP_MODE_2BPP: extract = {14'h0000, sh[1:0]};
         `LUPP_MODE_4BPP: extract = {12'h000, sh[3:0]};
         `LUPP_MODE_8BPP: extract = {8'h00, sh[7:0]};
         default:         extract = sh[15:0];
      endcase
   endfunction

   // exchange red and blue fields
   function automatic logic [15:0] swap_rb(input logic [15:0] c,
                                           input logic        is565);
      if (is565) swap_rb = {c[4:0], c[10:5], c[15:11]};
      else       swap_rb = {c[15], c[4:0], c[9:5], c[14:10]};
   endfunction

   // ----------------------------------------------------------------
   // registers and nets
   // ----------------------------------------------------------------
   logic [`LUPP_CTRL_WIDTH-1:0] ctrl_reg;
   lupp_pkg::lupp_bus_e         bus_reg;
   logic [31:0]                 up_word_reg;
   logic [31:0]                 lo_word_reg;
   logic                        up_full_reg;
   logic                        lo_full_reg;
   logic [4:0]                  slot_reg;
   logic                        side_reg;
   logic                        st_valid_reg;
   logic [15:0]                 st_raw_reg;
   logic                        st_pal_reg;
   logic                        st_high_reg;
   logic                        st_lower_reg;
   logic [2:0]                  mode;
   logic                        dual;
   logic                        is_pal;
   logic                        take;
   logic                        take_lower;
   logic                        is_last;
   logic                        pop_up;
   logic                        pop_lo;
   logic                        adv;
   logic [15:0]                 raw;
   logic [15:0]                 colour;
   logic [31:0]                 pal_b_data;
   logic [31:0]                 pal_a_data;
   logic                        fifo_in_ready;
   logic [LW-1:0]               fifo_level;
   logic                        bus_req;
   logic                        bus_pal;
   logic                        bus_fin;
   lupp_pkg::lupp_pix_s         pix_in;
   lupp_pkg::lupp_pix_s         pix_out;

   assign mode   = ctrl_reg[`LUPP_CTRL_MODE_MSB:`LUPP_CTRL_MODE_LSB];
   assign dual   = ctrl_reg[`LUPP_CTRL_DUAL];
   assign is_pal = (mode <= `LUPP_MODE_8BPP);

   // ----------------------------------------------------------------
   // word intake from the dma fifos
   // ----------------------------------------------------------------

   // pick the source of the next pixel and whether it is available
   assign take_lower = dual & side_reg;
   assign adv        = ~st_valid_reg | fifo_in_ready;
   assign take       = adv & ctrl_reg[`LUPP_CTRL_ENABLE] &
                       (take_lower ? lo_full_reg : up_full_reg);
   assign is_last    = (slot_reg == last_slot(mode));
   assign pop_up     = take & ~take_lower & is_last;
   assign pop_lo     = take & take_lower & is_last;

   // upper word holder, refilled only once emptied
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         up_full_reg <= 1'b0;
         up_word_reg <= 32'h0000_0000;
         UP_READY_O  <= 1'b0;
      end else if (CE_I) begin
         if (UP_VALID_I && UP_READY_O) begin
            up_word_reg <= UP_WORD_I;
            up_full_reg <= 1'b1;
            UP_READY_O  <= 1'b0;
         end else if (pop_up) begin
            up_full_reg <= 1'b0;
            UP_READY_O  <= 1'b1;
         end else begin
            UP_READY_O  <= ~up_full_reg;
         end
      end
   end

   // lower word holder, used in dual panel only
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         lo_full_reg <= 1'b0;
         lo_word_reg <= 32'h0000_0000;
         LO_READY_O  <= 1'b0;
      end else if (CE_I) begin
         if (LO_VALID_I && LO_READY_O) begin
            lo_word_reg <= LO_WORD_I;
            lo_full_reg <= 1'b1;
            LO_READY_O  <= 1'b0;
         end else if (pop_lo) begin
            lo_full_reg <= 1'b0;
            LO_READY_O  <= dual;
         end else begin
            LO_READY_O  <= ~lo_full_reg & dual;
         end
      end
   end

   // slot walk, low slot first, upper/lower alternate per pixel
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         slot_reg <= 5'h00;
         side_reg <= 1'b0;
      end else if (CE_I) begin
         if (!ctrl_reg[`LUPP_CTRL_ENABLE]) begin
            slot_reg <= 5'h00;
            side_reg <= 1'b0;
         end else if (take) begin
            side_reg <= dual & ~side_reg;
            if (!dual || side_reg) begin
               slot_reg <= is_last ? 5'h00 : slot_reg + 5'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // extraction stage and palette lookup issue
   // ----------------------------------------------------------------
   assign raw = extract(take_lower ? lo_word_reg : up_word_reg,
                        slot_reg, mode);

   // stage register in front of the palette output
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         st_valid_reg <= 1'b0;
         st_raw_reg   <= 16'h0000;
         st_pal_reg   <= 1'b0;
         st_high_reg  <= 1'b0;
         st_lower_reg <= 1'b0;
      end else if (CE_I && adv) begin
         st_valid_reg <= take;
         st_raw_reg   <= raw;
         st_pal_reg   <= is_pal;
         st_high_reg  <= raw[0] ^ ctrl_reg[`LUPP_CTRL_BIGEND];
         st_lower_reg <= take_lower;
      end
   end

   // ----------------------------------------------------------------
   // colour forming
   // ----------------------------------------------------------------
   always_comb begin
      colour = st_raw_reg;
      if (st_pal_reg) begin
         colour = st_high_reg ? pal_b_data[31:16] : pal_b_data[15:0];
      end else if (mode == `LUPP_MODE_12_444 ||
                   (mode == `LUPP_MODE_16_555 &&
                    ctrl_reg[`LUPP_CTRL_PASSIVE])) begin
         colour = st_raw_reg & 16'h7bde;
      end
      if (ctrl_reg[`LUPP_CTRL_SWAP]) begin
         colour = swap_rb(colour, ~st_pal_reg &&
                          mode == `LUPP_MODE_16_565);
      end
   end

   assign pix_in.lower  = st_lower_reg;
   assign pix_in.colour = colour;

   // ----------------------------------------------------------------
   // palette store and output fifo
   // ----------------------------------------------------------------
   lupp_palette #(
      .WORDS     (PAL_WORDS)
   ) u_palette (
      .clk_i     (MCLK_I),
      .rst_i     (SYS_RST_I),
      .ce_i      (CE_I),
      .a_en_i    (bus_req && bus_reg == lupp_pkg::BUS_IDLE),
      .a_we_i    (bus_fin && AV_WRITE_I && bus_pal),
      .a_be_i    (AV_BYTEENABLE_I),
      .a_addr_i  (AV_ADDRESS_I[PAW-1:0]),
      .a_wdata_i (AV_WRITEDATA_I),
      .a_rdata_o (pal_a_data),
      .b_en_i    (adv),
      .b_addr_i  (raw[PAW:1]),
      .b_rdata_o (pal_b_data)
   );

   lupp_fifo #(
      .WIDTH       ($bits(lupp_pkg::lupp_pix_s)),
      .DEPTH       (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (MCLK_I),
      .rst_i       (SYS_RST_I),
      .ce_i        (CE_I),
      .in_data_i   (pix_in),
      .in_valid_i  (st_valid_reg),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (pix_out),
      .out_valid_o (PIX_VALID_O),
      .out_ready_i (PIX_READY_I),
      .level_o     (fifo_level)
   );

   assign PIX_COLOUR_O = pix_out.colour;
   assign PIX_LOWER_O  = pix_out.lower;

   // ----------------------------------------------------------------
   // register slave
   // ----------------------------------------------------------------
   assign bus_req = AV_READ_I | AV_WRITE_I;
   assign bus_pal = AV_ADDRESS_I[`LUPP_PAL_SEL_BIT];
   assign bus_fin = bus_req & ~AV_WAITREQUEST_O;

   // three-phase access: look, answer, release
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         bus_reg          <= lupp_pkg::BUS_IDLE;
         AV_WAITREQUEST_O <= 1'b1;
         AV_READDATA_O    <= 32'h0000_0000;
      end else if (CE_I) begin
         unique case (bus_reg)
            lupp_pkg::BUS_IDLE: begin
               if (bus_req) bus_reg <= lupp_pkg::BUS_LOOK;
            end
            lupp_pkg::BUS_LOOK: begin
               bus_reg          <= lupp_pkg::BUS_DONE;
               AV_WAITREQUEST_O <= 1'b0;
               if (bus_pal) begin
                  AV_READDATA_O <= pal_a_data;
               end else if (AV_ADDRESS_I == `LUPP_CTRL_ADDR) begin
                  AV_READDATA_O <= {24'h00_0000, ctrl_reg};
               end else if (AV_ADDRESS_I == `LUPP_STATUS_ADDR) begin
                  AV_READDATA_O <= 32'h0000_0000;
                  AV_READDATA_O[`LUPP_STAT_LEVEL_LSB +: LW] <= fifo_level;
                  AV_READDATA_O[`LUPP_STAT_UP_FULL] <= up_full_reg;
                  AV_READDATA_O[`LUPP_STAT_LO_FULL] <= lo_full_reg;
               end else begin
                  AV_READDATA_O <= 32'h0000_0000;
               end
            end
            lupp_pkg::BUS_DONE: begin
               bus_reg          <= lupp_pkg::BUS_IDLE;
               AV_WAITREQUEST_O <= 1'b1;
            end
         endcase
      end
   end

   // control register write, low byte lane only
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         ctrl_reg <= `LUPP_CTRL_RESET;
      end else if (CE_I && bus_fin && AV_WRITE_I && !bus_pal &&
                   AV_ADDRESS_I == `LUPP_CTRL_ADDR &&
                   AV_BYTEENABLE_I[0]) begin
         ctrl_reg <= AV_WRITEDATA_I[`LUPP_CTRL_WIDTH-1:0];
      end
   end

endmodule

`default_nettype wire

//--- verification/lupp_top_assertions.sv
// port checks of the pixel unpack stage
// assumes CE_I held high and one clock
`timescale 1ns/1ps
`default_nettype none
module lupp_top_assertions (
   input wire logic        MCLK_I,
   input wire logic        SYS_RST_I,
   input wire logic        UP_VALID_I,
   input wire logic        UP_READY_O,
   input wire logic        LO_VALID_I,
   input wire logic        LO_READY_O,
   input wire logic [15:0] PIX_COLOUR_O,
   input wire logic        PIX_LOWER_O,
   input wire logic        PIX_VALID_O,
   input wire logic        PIX_READY_I,
   input wire logic        AV_READ_I,
   input wire logic        AV_WRITE_I,
   input wire logic [31:0] AV_READDATA_O,
   input wire logic        AV_WAITREQUEST_O
);
   // ----------------------------------------------------------
   // side of the last accepted pixel
   // ----------------------------------------------------------
   logic lo_reg;
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I)
         lo_reg <= 1'h0;
      else if (PIX_VALID_O && PIX_READY_I)
         lo_reg <= PIX_LOWER_O;
   end
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);
   property p_rst; $fell(SYS_RST_I) |->
      AV_WAITREQUEST_O && !PIX_VALID_O; endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_ans; $rose(AV_READ_I || AV_WRITE_I) |->
      AV_WAITREQUEST_O [*2] ##1 !AV_WAITREQUEST_O; endproperty
   a_ans: assert property (p_ans) else $error("bus answer");
   property p_one; !AV_WAITREQUEST_O |=> AV_WAITREQUEST_O; endproperty
   a_one: assert property (p_one) else $error("wait low long");
   property p_req; !AV_WAITREQUEST_O |-> AV_READ_I || AV_WRITE_I; endproperty
   a_req: assert property (p_req) else $error("answer no req");
   property p_rdh; AV_WAITREQUEST_O |-> $stable(AV_READDATA_O); endproperty
   a_rdh: assert property (p_rdh) else $error("rdata moved");
   property p_upt; UP_VALID_I && UP_READY_O |=> !UP_READY_O; endproperty
   a_upt: assert property (p_upt) else $error("holder not full");
   property p_lot; LO_VALID_I && LO_READY_O |=> !LO_READY_O; endproperty
   a_lot: assert property (p_lot) else $error("lower not full");
   property p_hold; PIX_VALID_O && !PIX_READY_I |=> PIX_VALID_O &&
      $stable({PIX_LOWER_O, PIX_COLOUR_O}); endproperty
   a_hold: assert property (p_hold) else $error("pixel dropped");
   property p_alt; PIX_VALID_O && PIX_READY_I && PIX_LOWER_O |-> !lo_reg;
   endproperty
   a_alt: assert property (p_alt) else $error("lower twice");
endmodule
bind lupp_top lupp_top_assertions lupp_top_assertions_i (
   .MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .UP_VALID_I(UP_VALID_I),
   .UP_READY_O(UP_READY_O), .PIX_COLOUR_O(PIX_COLOUR_O),
   .LO_VALID_I(LO_VALID_I), .LO_READY_O(LO_READY_O),
   .PIX_LOWER_O(PIX_LOWER_O), .PIX_VALID_O(PIX_VALID_O),
   .PIX_READY_I(PIX_READY_I), .AV_READ_I(AV_READ_I),
   .AV_WRITE_I(AV_WRITE_I), .AV_READDATA_O(AV_READDATA_O),
   .AV_WAITREQUEST_O(AV_WAITREQUEST_O));
`default_nettype wire

//--- verification/lupp_src.sv
// word source standing in for one dma fifo
// assumes the design's ready is a registered level
`timescale 1ns/1ps
`default_nettype none
module lupp_src (
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   input  wire logic   ready_i,
   output logic [31:0] word_o,
   output logic        valid_o
);
   logic [31:0] q[$];
   // words queued by the bench
   task automatic push(input logic [31:0] w);
      q.push_back(w);
   endtask
   // ----------------------------------------------------------
   // whole words held until taken, bubble after each
   // ----------------------------------------------------------
   initial begin
      word_o = 32'h0;
      valid_o = 1'h0;
      forever begin
         @(posedge clk_i);
         if (valid_o && ready_i)
            valid_o <= 1'h0;
         if (!valid_o && !rst_i && q.size() != 0 && $urandom % 2 == 0) begin
            word_o <= q.pop_front();
            valid_o <= 1'h1;
         end else if (!valid_o || ready_i)
            word_o <= ~word_o; // idle lines toggle
      end
   end
endmodule
`default_nettype wire

//--- verification/lupp_top_tb_top.sv
// bench for the pixel unpack stage: palette, modes, fifo fill
// assumes the source model and the checker compile first
`timescale 1ns/1ps
`default_nettype none
`include "lupp_defs.svh"
module lupp_top_tb_top;
   logic        mclk, rst, up_v, up_r, lo_v, lo_r, pix_l, pix_v, pix_r;
   logic        av_rd, av_wr, av_wt, stall;
   logic [31:0] up_w, lo_w, av_wd, av_q, rd, pw[128];
   logic [15:0] pix_c;
   logic [7:0]  av_a;
   logic [3:0]  av_be;
   int          errors, n_compared;
   lupp_pkg::lupp_pix_s exp_q[$];
   lupp_top lupp_top_i (.MCLK_I(mclk), .SYS_RST_I(rst), .CE_I(1'h1),
      .UP_WORD_I(up_w), .UP_VALID_I(up_v), .UP_READY_O(up_r),
      .LO_WORD_I(lo_w), .LO_VALID_I(lo_v), .LO_READY_O(lo_r),
      .PIX_COLOUR_O(pix_c), .PIX_LOWER_O(pix_l), .PIX_VALID_O(pix_v),
      .PIX_READY_I(pix_r), .AV_ADDRESS_I(av_a), .AV_READ_I(av_rd),
      .AV_WRITE_I(av_wr), .AV_WRITEDATA_I(av_wd), .AV_BYTEENABLE_I(av_be),
      .AV_READDATA_O(av_q), .AV_WAITREQUEST_O(av_wt));
   lupp_src lupp_src_up_i (.clk_i(mclk), .rst_i(rst), .ready_i(up_r),
      .word_o(up_w), .valid_o(up_v));
   lupp_src lupp_src_lo_i (.clk_i(mclk), .rst_i(rst), .ready_i(lo_r),
      .word_o(lo_w), .valid_o(lo_v));
   // ----------------------------------------------------------
   // clock, sink, pixel monitor
   // ----------------------------------------------------------
   initial begin
      mclk = 1'h0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) pix_r <= !stall && ($urandom % 4 != 0);
   always @(posedge mclk) begin
      if (!rst && pix_v === 1'h1 && pix_r === 1'h1) begin
         if (exp_q.size() == 0)
            chk(32'h1, 32'h0);
         else
            chk({pix_l, pix_c}, exp_q.pop_front());
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      int t;
      t = 0;
      av_a <= a;
      av_wd <= d;
      av_be <= be;
      av_wr <= wr;
      av_rd <= !wr;
      @(posedge mclk);
      while (av_wt !== 1'h0 && t < 100) begin
         @(posedge mclk);
         t++;
      end
      errors += (t == 100);
      rd = av_q;
      av_rd <= 1'h0;
      av_wr <= 1'h0;
      @(posedge mclk);
   endtask
   task automatic palw(input int n, input logic [31:0] d,
                       input logic [3:0] be);
      bus(1'h1, 8'h80 | n[7:0], d, be);
      for (int b = 0; b < 4; b++)
         if (be[b]) pw[n][8*b +: 8] = d[8*b +: 8];
   endtask
   // expected colour of pixel k of word w under control c
   function automatic logic [15:0] px(input logic [31:0] w, input int k,
                                      input logic [7:0] c);
      logic [15:0] h;
      logic [7:0]  x;
      int          n;
      n = c[2:0] < 3'h4 ? 1 << c[2:0] : 16;
      x = 8'((w >> (k * n)) & ((1 << n) - 1));
      h = k[0] ? w[31:16] : w[15:0];
      if (n < 16) h = x[0] ^ c[5] ? pw[x[7:1]][31:16] : pw[x[7:1]][15:0];
      else if (c[2:0] == 3'h6 || (c[2:0] == 3'h4 && c[6])) h = h & 16'h7bde;
      if (c[4] && c[2:0] == 3'h5) h = {h[4:0], h[10:5], h[15:11]};
      else if (c[4]) h = {h[15], h[4:0], h[9:5], h[14:10]};
      return h;
   endfunction
   task automatic feed(input logic [7:0] c, input int nw);
      logic [31:0] wu, wl;
      bus(1'h1, `LUPP_CTRL_ADDR, {24'h0, c}, 4'hf);
      bus(1'h0, `LUPP_CTRL_ADDR, 32'h0, 4'hf);
      chk(rd, {24'h0, c});
      for (int i = 0; i < nw; i++) begin
         wu = i == 0 ? 32'h8421_7bde : $urandom;
         wl = $urandom;
         lupp_src_up_i.push(wu);
         if (c[3]) lupp_src_lo_i.push(wl);
         for (int k = 0; k < (c[2:0] < 3'h4 ? 32 >> c[2:0] : 2); k++) begin
            exp_q.push_back({1'h0, px(wu, k, c)});
            if (c[3]) exp_q.push_back({1'h1, px(wl, k, c)});
         end
      end
      bus(1'h0, 8'h80 | c[6:0], 32'h0, 4'hf);
      chk(rd, pw[c[6:0]]);
   endtask
   task automatic drain;
      int t;
      t = 0;
      while (exp_q.size() != 0 && t < 5000) begin
         @(posedge mclk);
         t++;
      end
      errors += (t == 5000);
      bus(1'h1, `LUPP_CTRL_ADDR, 32'h0, 4'hf);
   endtask
   task automatic summarize;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------
   initial begin
      {rst, av_rd, av_wr, av_a, av_wd, av_be, stall} = 48'h0;
      rst = 1'h1;
      errors = 0;
      n_compared = 0;
      void'($urandom(32'h7ade8faa));
      repeat (20) @(posedge mclk);
      rst <= 1'h0;
      @(posedge mclk);
      for (int i = 0; i < 128; i++) palw(i, $urandom, 4'hf);
      palw(9, 32'hffff_ffff, 4'h5);
      for (int i = 0; i < 128; i += 9) begin
         bus(1'h0, 8'h80 | i[7:0], 32'h0, 4'hf);
         chk(rd, pw[i]);
      end
      bus(1'h1, 8'h40, 32'h1234_5678, 4'hf);
      bus(1'h0, 8'h40, 32'h0, 4'hf);
      chk(rd, 32'h0);
      for (int m = 0; m < 32; m++) begin
         feed({1'h1, 1'($urandom), m[3], m[4], 1'($urandom), m[2:0]}, 2);
         drain();
      end
      stall <= 1'h1;
      feed(8'h80, 2);
      repeat (300) @(posedge mclk);
      bus(1'h0, `LUPP_STATUS_ADDR, 32'h0, 4'hf);
      chk(rd, {18'h0, 6'h20, 6'h0, 2'h1});
      stall <= 1'h0;
      drain();
      bus(1'h0, `LUPP_STATUS_ADDR, 32'h0, 4'hf);
      chk(rd, 32'h0);
      summarize();
   end
   initial begin
      repeat (60000) @(posedge mclk);
      errors++;
      summarize();
   end
endmodule
`default_nettype wire
